// [design/gct_top.sv]
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// - Count logic advances on slow 32KHz clock edges
// - Register accesses never wait on slow clock
// - Load count, then enable; counting starts
// - Disable stops counting and gates slow clock
// - Underflow raises expiry and sets status flag
// - Reload on load write, kick, or expiry
// - Interval is load value down to zero
// - Decrement once every 33 slow periods
// - Enabled asserted hold input freezes counting
// - Hold release resumes from frozen count
// - Expiry output is a pulse
// - System reset restores all defaults except expiry flag
// - Expiry flag cleared by alternate reset or status write one
// - Expiry event cleared by system reset
// - Load register 16 bits RW, all ones
// - Control bit 4 holds on debug activity
// - Control bit 3 holds on week timer
// - Control bit 2 holds on sleep timer 0
// - Bit 0 enable, bit 1 reads zero
// - Kick register reloads when enabled, reads zero
// - Count register read-only, resets to ones
module gct_top
  import gct_pkg::*;
(
  input  wire logic              aclk,                  // Host clock
  input  wire logic              aresetn,               // System reset
  input  wire logic              keep_resetn,           // Alternate reset
  input  wire logic              slow_clk_in,           // 32KHz clock level
  input  wire logic              debug_active,          // Debug session on
  input  wire logic              week_timer_active,     // Week timer on
  input  wire logic              sleep_counter0_active, // Sleep timer 0 on
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,          // Write address
  input  wire logic              s_axi_awvalid,         // Write addr valid
  output logic                   s_axi_awready,         // Write addr ready
  input  wire logic [31:0]       s_axi_wdata,           // Write data
  input  wire logic [3:0]        s_axi_wstrb,           // Byte enables
  input  wire logic              s_axi_wvalid,          // Write data valid
  output logic                   s_axi_wready,          // Write data ready
  output logic [1:0]             s_axi_bresp,           // Write response
  output logic                   s_axi_bvalid,          // Response valid
  input  wire logic              s_axi_bready,          // Response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,          // Read address
  input  wire logic              s_axi_arvalid,         // Read addr valid
  output logic                   s_axi_arready,         // Read addr ready
  output logic [31:0]            s_axi_rdata,           // Read data
  output logic [1:0]             s_axi_rresp,           // Read response
  output logic                   s_axi_rvalid,          // Read data valid
  input  wire logic              s_axi_rready,          // Read data ready
  output logic                   expiry_event,          // Subsystem reset
  output logic                   expiry_flag            // Sticky status
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic [CNT_W-1:0]  reload_value_reg;
  logic [CTL_W-1:0]  control_reg;
  logic [CNT_W-1:0]  current_count_reg;
  logic [PRESC_W-1:0] presc_reg;
  logic              slow_prev_reg;
  logic              expiry_event_reg;
  logic              expiry_flag_reg;
  logic              expiry_flag_next;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic              wr_fire;
  logic              wr_reload;
  logic              wr_control;
  logic              wr_refresh;
  logic              wr_status;
  logic              wr_mapped;
  logic              guard_enable_bit;
  logic              hold_active;
  logic              running;
  logic              slow_edge;
  logic              count_step;
  logic              underflow;
  logic [CNT_W-1:0]  reload_merged;
  logic [CTL_W-1:0]  control_merged;
  logic [31:0]       rd_word;
  logic              rd_mapped;

  // A write is carried out once both address and data have been taken,
  // and only while no response is still waiting for the master.
  assign wr_fire    = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_reload  = wr_fire && (waddr_reg == RELOAD_OFS);
  assign wr_control = wr_fire && (waddr_reg == CONTROL_OFS);
  assign wr_refresh = wr_fire && (waddr_reg == REFRESH_OFS);
  assign wr_status  = wr_fire && (waddr_reg == STATUS_OFS);
  assign wr_mapped  = wr_reload || wr_control || wr_refresh || wr_status
                      || (waddr_reg == COUNT_OFS);

  assign reload_merged[7:0]  = wstrb_reg[0] ? wdata_reg[7:0]
                                            : reload_value_reg[7:0];
  assign reload_merged[15:8] = wstrb_reg[1] ? wdata_reg[15:8]
                                            : reload_value_reg[15:8];
  assign control_merged      = wstrb_reg[0]
                               ? (wdata_reg[7:0] & CTL_WR_MASK)
                               : control_reg;

  // ----------------------------------------------------------------------
  // Counting conditions
  // ----------------------------------------------------------------------
  assign guard_enable_bit = control_reg[CTL_ENABLE_BIT];

  assign hold_active =
      (control_reg[CTL_DEBUG_BIT]  && debug_active)
   || (control_reg[CTL_WEEK_BIT]   && week_timer_active)
   || (control_reg[CTL_SLEEP0_BIT] && sleep_counter0_active);

  // The slow edge is only consumed while running, which is how the
  // counting clock is gated when disabled or held.
  assign running    = guard_enable_bit && !hold_active;
  assign slow_edge  = slow_clk_in && !slow_prev_reg;
  assign count_step = running && slow_edge
                      && (presc_reg == PRESC_LAST);
  assign underflow  = count_step
                      && (current_count_reg == '0);

  // ----------------------------------------------------------------------
  // Write address and data channels
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      waddr_reg   <= '0;
    end
    else if (s_axi_awvalid && awready_reg)
    begin
      awready_reg <= 1'b0;
      aw_have_reg <= 1'b1;
      waddr_reg   <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_have_reg <= 1'b0;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_reg <= 1'b1;
      w_have_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (s_axi_wvalid && wready_reg)
    begin
      wready_reg <= 1'b0;
      w_have_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_have_reg <= 1'b0;
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      wready_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------------
  // Writes finish in the host domain without looking at the slow clock.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_word   = '0;
    rd_mapped = 1'b1;
    unique case (s_axi_araddr)
      RELOAD_OFS:  rd_word[CNT_W-1:0] = reload_value_reg;
      CONTROL_OFS: rd_word[CTL_W-1:0] = control_reg;
      REFRESH_OFS: rd_word            = '0;
      COUNT_OFS:   rd_word[CNT_W-1:0] = current_count_reg;
      STATUS_OFS:  rd_word[STS_EXPIRY_BIT] = expiry_flag_reg;
      default:     rd_mapped          = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_reg   <= rd_word;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Load and control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reload_value_reg <= RELOAD_RST;
    end
    else if (wr_reload)
    begin
      reload_value_reg <= reload_merged;
    end
  end

  // Bit 1 and bits 7:5 are masked off, so they always read zero.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg <= CTL_RST;
    end
    else if (wr_control)
    begin
      control_reg <= control_merged;
    end
  end

  // ----------------------------------------------------------------------
  // Slow clock sampling and prescaler
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_prev_reg <= 1'b0;
    end
    else
    begin
      slow_prev_reg <= slow_clk_in;
    end
  end

  // Any reload restarts the 33-period step so every count lasts in full.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      presc_reg <= '0;
    end
    else if (wr_reload || (wr_refresh && guard_enable_bit))
    begin
      presc_reg <= '0;
    end
    else if (running && slow_edge)
    begin
      if (presc_reg == PRESC_LAST)
      begin
        presc_reg <= '0;
      end
      else
      begin
        presc_reg <= presc_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------------
  // While held or disabled the count simply stays, so counting resumes
  // from the same value once the hold lifts.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      current_count_reg <= COUNT_RST;
    end
    else if (wr_reload)
    begin
      current_count_reg <= reload_merged;
    end
    else if (wr_refresh && guard_enable_bit)
    begin
      current_count_reg <= reload_value_reg;
    end
    else if (underflow)
    begin
      current_count_reg <= reload_value_reg;
    end
    else if (count_step)
    begin
      current_count_reg <= current_count_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Expiry output and sticky status
  // ----------------------------------------------------------------------
  // The pulse spans one slow period: raised at the underflow edge and
  // dropped at the next slow edge, whether or not counting goes on.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      expiry_event_reg <= 1'b0;
    end
    else if (underflow)
    begin
      expiry_event_reg <= 1'b1;
    end
    else if (slow_edge)
    begin
      expiry_event_reg <= 1'b0;
    end
  end

  // Write one to clear; a new expiry in the same cycle wins.
  assign expiry_flag_next =
      underflow
   || (expiry_flag_reg
       && !(wr_status && wstrb_reg[0] && wdata_reg[STS_EXPIRY_BIT]));

  always_ff @(posedge aclk)
  begin
    if (!keep_resetn)
    begin
      expiry_flag_reg <= 1'b0;
    end
    else
    begin
      expiry_flag_reg <= expiry_flag_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign expiry_event  = expiry_event_reg;
  assign expiry_flag   = expiry_flag_reg;

endmodule : gct_top

// [design/gct_pkg.sv]
package gct_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite bus)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  RELOAD_OFS     = 8'h00;
  localparam logic [7:0]  CONTROL_OFS    = 8'h04;
  localparam logic [7:0]  REFRESH_OFS    = 8'h08;
  localparam logic [7:0]  COUNT_OFS      = 8'h0C;
  localparam logic [7:0]  STATUS_OFS     = 8'h10;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned CTL_W          = 8;
  localparam int unsigned CTL_ENABLE_BIT = 0;
  localparam int unsigned CTL_SLEEP0_BIT = 2;
  localparam int unsigned CTL_WEEK_BIT   = 3;
  localparam int unsigned CTL_DEBUG_BIT  = 4;
  localparam int unsigned STS_EXPIRY_BIT = 0;
  localparam logic [7:0]  CTL_WR_MASK    = 8'h1D;
  localparam logic [15:0] RELOAD_RST     = 16'hFFFF;
  localparam logic [15:0] COUNT_RST      = 16'hFFFF;
  localparam logic [7:0]  CTL_RST        = 8'h00;

  // ----------------------------------------------------------------------
  // Timing: one count every 33 periods of the slow clock
  // ----------------------------------------------------------------------
  localparam int unsigned SLOW_PER_COUNT = 33;
  localparam int unsigned PRESC_W        = 6;
  localparam logic [5:0]  PRESC_LAST     = 6'(SLOW_PER_COUNT - 1);

  // ----------------------------------------------------------------------
  // AXI4-Lite responses
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : gct_pkg

// [testbench/gct_slow_src.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Slow clock source
// ---------------------------------------------------------------
// The slow clock runs at a scaled rate so that one count costs
// hundreds of host cycles, not thousands; the bench derives its
// count and pulse waits from HALF.
module gct_slow_src #(
  parameter int HALF = 8
) (
  input  wire logic aclk,     // Host clock
  output logic      slow_clk  // Slow clock level
);
  int unsigned ph = 0;

  initial slow_clk = 1'b0;

  always @(posedge aclk)
  begin
    if (ph == HALF - 1)
    begin
      ph <= 0;
      slow_clk <= ~slow_clk;
    end
    else
      ph <= ph + 1;
  end
endmodule : gct_slow_src

// [testbench/gct_checker.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Bus and expiry checks
// ---------------------------------------------------------------
module gct_checker
  import gct_pkg::*;
(
  input wire logic        aclk,           // Clock
  input wire logic        aresetn,        // Reset
  input wire logic        keep_resetn,    // Alt reset
  input wire logic        slow_clk_in,    // Slow clock
  input wire logic        s_axi_awvalid,  // AW valid
  input wire logic        s_axi_awready,  // AW ready
  input wire logic        s_axi_wvalid,   // W valid
  input wire logic        s_axi_wready,   // W ready
  input wire logic [1:0]  s_axi_bresp,    // B resp
  input wire logic        s_axi_bvalid,   // B valid
  input wire logic        s_axi_bready,   // B ready
  input wire logic        s_axi_arvalid,  // AR valid
  input wire logic        s_axi_arready,  // AR ready
  input wire logic [31:0] s_axi_rdata,    // R data
  input wire logic        s_axi_rvalid,   // R valid
  input wire logic        s_axi_rready,   // R ready
  input wire logic        expiry_event,   // Expiry pulse
  input wire logic        expiry_flag     // Sticky flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_pulse_live;
    expiry_event && $rose(slow_clk_in);
  endsequence

  property p_wr_answer;
    s_wr_both |-> ##[1:2] s_axi_bvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_rd_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_pulse_end;
    s_pulse_live |-> ##[1:3] !expiry_event;
  endproperty
  property p_flag_set;
    $rose(expiry_event) |-> ##[0:1] expiry_flag;
  endproperty
  property p_flag_keep;
    expiry_flag && keep_resetn && s_axi_awready |=> expiry_flag;
  endproperty
  property p_rst;
    disable iff (1'b0)
    !aresetn |=> !expiry_event && !s_axi_bvalid && !s_axi_rvalid;
  endproperty

  a_wr_answer: assert property (p_wr_answer)
    else $error("write answer late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_rd_busy: assert property (p_rd_busy)
    else $error("read accepted while busy");
  a_pulse_end: assert property (p_pulse_end)
    else $error("expiry pulse too long");
  a_flag_set: assert property (p_flag_set)
    else $error("expiry without flag");
  a_flag_keep: assert property (p_flag_keep)
    else $error("flag lost");
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
endmodule : gct_checker

bind gct_top gct_checker u_chk (
  .aclk, .aresetn, .keep_resetn, .slow_clk_in, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .expiry_event,
  .expiry_flag
);

// [testbench/watchdog_timer_block_test.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Watchdog bench
// ---------------------------------------------------------------
module watchdog_timer_block_test;
  import gct_pkg::*;
  localparam int HALF = 8;
  localparam int STEP = 33 * 2 * HALF;  // Host cycles per count.

  logic        aclk;
  logic        aresetn       = 1'b0;
  logic        keep_resetn   = 1'b0;
  logic        slow_clk_in;
  logic [2:0]  hold          = 3'h0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        expiry_event, expiry_flag;
  int          n_mismatch    = 0;
  int          checked       = 0;

  gct_slow_src #(.HALF(HALF)) u_slow (.aclk, .slow_clk(slow_clk_in));

  gct_top DUT (
    .aclk, .aresetn, .keep_resetn, .slow_clk_in,
    .debug_active(hold[2]), .week_timer_active(hold[1]),
    .sleep_counter0_active(hold[0]),
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .expiry_event, .expiry_flag
  );

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // Address and data are offered together; each drops once taken.
  // An edge passes first, so a ready released by the previous call is
  // never raised again in the same time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ev,
                    input string nm, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(nm, s_axi_rdata, ev);
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : rd

  task automatic t_defaults;
    rd(RELOAD_OFS, 32'hFFFF, "reload");
    rd(CONTROL_OFS, 32'h0, "control");
    rd(REFRESH_OFS, 32'h0, "kick");
    rd(COUNT_OFS, 32'hFFFF, "count");
  endtask : t_defaults

  task automatic t_access;
    wr(RELOAD_OFS, 32'hABCD1234);
    rd(RELOAD_OFS, 32'h1234, "reload");
    rd(COUNT_OFS, 32'h1234, "load copy");
    wr(COUNT_OFS, 32'h0);
    rd(COUNT_OFS, 32'h1234, "count ro");
    wr(CONTROL_OFS, 32'hFF);
    rd(CONTROL_OFS, 32'h1D, "control");
    wr(CONTROL_OFS, 32'h0);
    wr(8'h14, 32'h0, RESP_SLVERR);
    rd(8'h14, 32'h0, "unmapped", RESP_SLVERR);
  endtask : t_access

  task automatic t_rate;
    wr(RELOAD_OFS, 32'h3);
    wr(CONTROL_OFS, 32'h1);
    idle(STEP / 2);
    rd(COUNT_OFS, 32'h3, "count");
    idle(STEP);
    rd(COUNT_OFS, 32'h2, "count");
    wr(CONTROL_OFS, 32'h0);
    idle(2 * STEP);
    rd(COUNT_OFS, 32'h2, "stopped");
    wr(REFRESH_OFS, 32'h0);
    rd(COUNT_OFS, 32'h2, "kick off");
    wr(CONTROL_OFS, 32'h1);
    wr(REFRESH_OFS, 32'h0);
    rd(COUNT_OFS, 32'h3, "kicked");
  endtask : t_rate

  task automatic t_hold;
    for (int i = 0; i < 3; i++)
    begin
      wr(RELOAD_OFS, 32'h5);
      wr(CONTROL_OFS, 32'h1 | (32'h4 << i));
      hold[i] <= 1'b1;
      idle(2 * STEP);
      rd(COUNT_OFS, 32'h5, "held");
      hold[i] <= 1'b0;
      idle(3 * STEP / 2);
      rd(COUNT_OFS, 32'h4, "resumed");
    end
    wr(RELOAD_OFS, 32'h5);
    wr(CONTROL_OFS, 32'h1);
    hold <= 3'h7;
    idle(3 * STEP / 2);
    rd(COUNT_OFS, 32'h4, "unheld");
    hold <= 3'h0;
  endtask : t_hold

  // Firmware kicks once per count, well inside the two-count interval.
  task automatic t_service;
    wr(RELOAD_OFS, 32'h1);
    wr(CONTROL_OFS, 32'h1);
    repeat (4)
    begin
      idle(STEP);
      wr(REFRESH_OFS, 32'h0);
      chk("serviced", 32'(expiry_flag), 32'h0);
    end
    wr(CONTROL_OFS, 32'h0);
  endtask : t_service

  task automatic t_expiry;
    int n = 0;
    wr(RELOAD_OFS, 32'h1);
    wr(CONTROL_OFS, 32'h1);
    while (expiry_event !== 1'b1 && n < 3 * STEP)
    begin
      @(posedge aclk);
      n++;
    end
    chk("steps", (n + STEP / 2) / STEP, 32'h2);
    chk("flag", 32'(expiry_flag), 32'h1);
    rd(STATUS_OFS, 32'h1, "status");
    rd(COUNT_OFS, 32'h1, "reloaded");
    idle(4 * HALF + 4);
    chk("pulse", 32'(expiry_event), 32'h0);
    aresetn <= 1'b0;
    idle(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("flag kept", 32'(expiry_flag), 32'h1);
    chk("event", 32'(expiry_event), 32'h0);
    rd(CONTROL_OFS, 32'h0, "control");
    rd(COUNT_OFS, 32'hFFFF, "count");
    keep_resetn <= 1'b0;
    @(posedge aclk);
    keep_resetn <= 1'b1;
    @(posedge aclk);
    chk("flag clear", 32'(expiry_flag), 32'h0);
  endtask : t_expiry

  initial
  begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn     <= 1'b1;
    keep_resetn <= 1'b1;
    @(posedge aclk);
    t_defaults();
    t_access();
    t_rate();
    t_hold();
    t_service();
    t_expiry();
    final_report();
  end
endmodule : watchdog_timer_block_test
